//--- core/mcuops_core.sv
// Purpose: Executes subtract-immediate, table read, timer0 mode moves, XOR
// Assumes: One op per cycle when op_ready; file register data is combinational
// Notes:   Table read holds op_ready low for its second cycle
//          Requests offered during that cycle are dropped, not queued
//
// How it works
// RQ1 - Immediate minus work register, flags, one cycle
// RQ2 - Carry set when no borrow occurs
// RQ3 - Table read: ROM at pointer, low byte
// RQ4 - ROM upper six bits to high data
// RQ5 - Work register to timer0 mode, one cycle
// RQ6 - Timer0 mode to work register, one cycle
// RQ7 - XOR with file register, destination bit
// RQ8 - XOR immediate into work register, zero only
// RQ9 - Zero flag tracks written result
`timescale 1ns/1ns
module mcuops_core (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        op_valid,
    input  wire mcuops_pkg::mcuops_op_e      op_code,
    input  wire logic [mcuops_pkg::DW-1:0]   op_imm,
    input  wire logic [mcuops_pkg::FAW-1:0]  op_faddr,
    input  wire logic                        op_dest,
    input  wire logic [mcuops_pkg::DW-1:0]   file_rdata,
    input  wire logic [mcuops_pkg::DW-1:0]   table_high_pointer,
    input  wire logic [mcuops_pkg::ROMW-1:0] rom_rdata,
    output logic                             op_ready,
    output logic [mcuops_pkg::FAW-1:0]       file_addr,
    output logic                             file_we,
    output logic [mcuops_pkg::DW-1:0]        file_wdata,
    output logic [mcuops_pkg::ROMAW-1:0]     rom_addr,
    output logic [mcuops_pkg::DW-1:0]        work_register,
    output logic [mcuops_pkg::DW-1:0]        timer0_mode_reg,
    output logic [mcuops_pkg::DW-1:0]        table_high_data,
    output logic                             zero_flag,
    output logic                             half_carry_flag,
    output logic                             carry_flag
);
    import mcuops_pkg::*;

    // Only the table read needs a second cycle, so two states suffice
    typedef enum logic {MCUOPS_IDLE, MCUOPS_TWAIT} mcuops_st_e;

    // Registered state and the arithmetic behind the next values
    mcuops_st_e        st_ff, nxt_st;
    logic [DW-1:0]     acc_ff, nxt_acc;
    logic [DW-1:0]     timer0_mode_reg_ff, nxt_timer0_mode_reg;
    logic [HD_W-1:0]   thd_ff, nxt_thd;
    logic              z_ff, nxt_z;
    logic              dc_ff, nxt_dc;
    logic              c_ff, nxt_c;
    logic [DW:0]       sub_full;
    logic [HALF_BIT:0] sub_half;
    logic [DW-1:0]     xr_res;
    logic              go;

    // The ROM address is held over both cycles so a synchronous ROM works
    // Only the pointer's three low bits reach the address
    assign rom_addr   = {table_high_pointer[PTR_HI:PTR_LO], acc_ff}; // RQ3
    assign op_ready   = (st_ff == MCUOPS_IDLE);
    assign go         = op_valid && op_ready;
    assign file_addr  = op_faddr;
    assign xr_res     = acc_ff ^ file_rdata;
    assign file_wdata = xr_res;
    // Write strobe lasts only the cycle in which the request is taken
    assign file_we    = go && (op_code == MCUOPS_XORR) && op_dest; // RQ7

    // Adding the inverse plus one: carry out high means no borrow
    assign sub_full = {1'h0, op_imm} + {1'h0, ~acc_ff} + 9'h001; // RQ1
    // Half carry is the same sum cut at the low nibble
    assign sub_half = {1'h0, op_imm[HALF_BIT-1:0]}
                    + {1'h0, ~acc_ff[HALF_BIT-1:0]} + 5'h01;

    // Next state of work register, timer0 mode, high data and flags
    always_comb begin
        nxt_st   = st_ff;
        nxt_acc  = acc_ff;
        nxt_timer0_mode_reg = timer0_mode_reg_ff;
        nxt_thd  = thd_ff;
        nxt_z    = z_ff;
        nxt_dc   = dc_ff;
        nxt_c    = c_ff;
        if (st_ff == MCUOPS_TWAIT) begin
            // Second cycle: flags untouched
            nxt_acc = rom_rdata[DW-1:0];            // RQ3
            nxt_thd = rom_rdata[ROMW-1:DW];         // RQ4
            nxt_st  = MCUOPS_IDLE;
        end else if (go) begin
            // NOP falls to the default and leaves every register alone
            case (op_code)
                MCUOPS_SUBI: begin
                    nxt_acc = sub_full[DW-1:0];     // RQ1
                    nxt_c   = sub_full[DW];         // RQ2
                    nxt_dc  = sub_half[HALF_BIT];   // RQ1
                    nxt_z   = (sub_full[DW-1:0] == RST_BYTE); // RQ9
                end
                MCUOPS_TABLE: nxt_st = MCUOPS_TWAIT; // RQ3
                MCUOPS_T0LOAD: nxt_timer0_mode_reg = acc_ff;   // RQ5
                MCUOPS_T0READ: nxt_acc = timer0_mode_reg_ff;   // RQ6
                MCUOPS_XORR: begin
                    if (!op_dest) begin
                        nxt_acc = xr_res;           // RQ7
                    end
                    nxt_z = (xr_res == RST_BYTE);   // RQ9
                end
                MCUOPS_XORI: begin
                    nxt_acc = acc_ff ^ op_imm;      // RQ8
                    nxt_z   = ((acc_ff ^ op_imm) == RST_BYTE); // RQ9
                end
                default: nxt_st = st_ff;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff   <= MCUOPS_IDLE;
            acc_ff  <= RST_BYTE;
            timer0_mode_reg_ff <= RST_BYTE;
            thd_ff  <= RST_HD;
            z_ff    <= 1'h0;
            dc_ff   <= 1'h0;
            c_ff    <= 1'h0;
        end else begin
            st_ff   <= nxt_st;
            acc_ff  <= nxt_acc;
            timer0_mode_reg_ff <= nxt_timer0_mode_reg;
            thd_ff  <= nxt_thd;
            z_ff    <= nxt_z;
            dc_ff   <= nxt_dc;
            c_ff    <= nxt_c;
        end
    end

    // Outputs come straight from the flip-flops
    assign work_register   = acc_ff;
    assign timer0_mode_reg = timer0_mode_reg_ff;
    assign table_high_data = {2'h0, thd_ff}; // Upper bits read zero
    assign zero_flag       = z_ff;
    assign half_carry_flag = dc_ff;
    assign carry_flag      = c_ff;

    // Checks run on the core clock and stay quiet during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Subtract: result, carry as no borrow, half carry from the low nibble
    chk_subi_result: assert property ( // RQ1
        go && op_code == MCUOPS_SUBI |=>
            acc_ff == DW'($past(op_imm) - $past(acc_ff)))
        else $error("subtract result wrong");
    chk_subi_carry: assert property ( // RQ2
        go && op_code == MCUOPS_SUBI |=>
            c_ff == ($past(op_imm) >= $past(acc_ff)))
        else $error("subtract carry wrong");
    chk_subi_half: assert property ( // RQ1
        go && op_code == MCUOPS_SUBI |=> dc_ff ==
            ($past(op_imm[HALF_BIT-1:0]) >= $past(acc_ff[HALF_BIT-1:0])))
        else $error("subtract half carry wrong");

    // Table read: busy for one cycle, then both parts load, flags kept
    chk_table_two: assert property ( // RQ3
        go && op_code == MCUOPS_TABLE |=> !op_ready ##1 op_ready)
        else $error("table read not two cycles");
    chk_table_flags: assert property ( // RQ4
        go && op_code == MCUOPS_TABLE |=> $stable({z_ff, c_ff, dc_ff}))
        else $error("table read first cycle changed flags");
    chk_busy_quiet: assert property ( // RQ3
        st_ff == MCUOPS_TWAIT |-> !op_ready && !file_we)
        else $error("request taken during table read");
    chk_table_data: assert property ( // RQ4
        st_ff == MCUOPS_TWAIT |=> thd_ff == $past(rom_rdata[ROMW-1:DW])
            && acc_ff == $past(rom_rdata[DW-1:0])
            && $stable({z_ff, c_ff, dc_ff}))
        else $error("table data or flags wrong");
    chk_thd_hold: assert property ( // RQ4
        st_ff != MCUOPS_TWAIT |=> $stable(thd_ff))
        else $error("table high data changed outside table read");

    // Timer0 mode moves touch no flag
    chk_t0_load: assert property ( // RQ5
        go && op_code == MCUOPS_T0LOAD |=>
            timer0_mode_reg_ff == $past(acc_ff) && $stable({z_ff, c_ff, dc_ff}))
        else $error("timer0 mode load wrong");
    chk_t0_hold: assert property ( // RQ5
        !(go && op_code == MCUOPS_T0LOAD) |=> $stable(timer0_mode_reg_ff))
        else $error("timer0 mode changed without load");
    chk_t0_read: assert property ( // RQ6
        go && op_code == MCUOPS_T0READ |=> acc_ff == $past(timer0_mode_reg_ff)
            && $stable({z_ff, c_ff, dc_ff}))
        else $error("timer0 mode read wrong");

    // XOR forms: only the zero flag may move
    chk_xorr_dest: assert property ( // RQ7
        go && op_code == MCUOPS_XORR && op_dest |=> $stable(acc_ff)
            && z_ff == ($past(xr_res) == RST_BYTE))
        else $error("register xor to file wrong");
    chk_xorr_acc: assert property ( // RQ7
        go && op_code == MCUOPS_XORR && !op_dest |=>
            acc_ff == ($past(acc_ff) ^ $past(file_rdata)) && $stable(c_ff))
        else $error("register xor to work register wrong");
    chk_xori_flags: assert property ( // RQ8
        go && op_code == MCUOPS_XORI |=> $stable(c_ff) && $stable(dc_ff)
            && acc_ff == ($past(acc_ff) ^ $past(op_imm)))
        else $error("immediate xor wrong");

    // Zero flag follows the byte written to the work register
    chk_zero_flag: assert property ( // RQ9
        go && (op_code inside {MCUOPS_SUBI, MCUOPS_XORI} ||
               (op_code == MCUOPS_XORR && !op_dest)) |=>
            z_ff == (acc_ff == RST_BYTE))
        else $error("zero flag wrong");

    // Main scenarios
    cov_subi: cover property (go && op_code == MCUOPS_SUBI);
    cov_table: cover property (st_ff == MCUOPS_TWAIT);
    cov_xorr_file: cover property (file_we);
    cov_zero: cover property (go && op_code == MCUOPS_XORI ##1 z_ff);
    cov_subi_borrow: cover property (go && op_code == MCUOPS_SUBI ##1 !c_ff);
endmodule : mcuops_core

//--- core/mcuops_pkg.sv
// Purpose: Shared constants for the ALU/table-read execution slice
// Assumes: 8-bit data path, 14-bit program ROM words, 11-bit ROM address
// Notes:   Operation codes are local to this block
package mcuops_pkg;
    localparam int DW        = 8;
    localparam int ROMW      = 14;
    localparam int ROMAW     = 11;
    localparam int FAW       = 7;
    localparam int PTR_LO    = 0;
    localparam int PTR_HI    = 2;
    localparam int HD_W      = 6;
    localparam int HALF_BIT  = 4;
    localparam logic [DW-1:0]   RST_BYTE = 8'h00;
    localparam logic [HD_W-1:0] RST_HD   = 6'h00;

    // Operation selector presented with op_valid
    typedef enum logic [2:0] {
        MCUOPS_NOP      = 3'h0,
        MCUOPS_SUBI     = 3'h1,
        MCUOPS_TABLE    = 3'h2,
        MCUOPS_T0LOAD   = 3'h3,
        MCUOPS_T0READ   = 3'h4,
        MCUOPS_XORR     = 3'h5,
        MCUOPS_XORI     = 3'h6
    } mcuops_op_e;
endpackage : mcuops_pkg

//--- dv/testbench.sv
// Purpose: Self-checking bench for the ALU and table-read execution slice
// Assumes: Bench plays file registers and program ROM, both combinational
// Notes:   Random ops from a fixed seed, with hand-picked corners first
`timescale 1ns/1ns
module testbench;
    import mcuops_pkg::*;
    logic               clk = 0, rst_n = 0, op_valid = 0, op_dest = 0;
    mcuops_op_e         op_code = MCUOPS_NOP;
    logic [DW-1:0]      op_imm = 8'h00, table_high_pointer = 8'h00;
    logic [FAW-1:0]     op_faddr = 7'h00, file_addr;
    logic [DW-1:0]      file_rdata, file_wdata, work_register;
    logic [DW-1:0]      timer0_mode_reg, table_high_data, m_acc, m_t0, m_hd;
    logic [ROMAW-1:0]   rom_addr;
    logic [ROMW-1:0]    rom_rdata;
    logic               op_ready, file_we, zero_flag, half_carry_flag;
    logic               carry_flag, m_z, m_dc, m_c;
    logic [DW-1:0]      fmem [128];
    int                 fails = 0, check_count = 0, seed = 44;
    mcuops_op_e         k;
    logic [DW-1:0]      r_imm;

    mcuops_core mcuops_core_inst (.clk, .rst_n, .op_valid, .op_code, .op_imm,
        .op_faddr, .op_dest, .file_rdata, .table_high_pointer, .rom_rdata,
        .op_ready, .file_addr, .file_we, .file_wdata, .rom_addr,
        .work_register, .timer0_mode_reg, .table_high_data, .zero_flag,
        .half_carry_flag, .carry_flag);

    function automatic logic [ROMW-1:0] rom_f(input logic [ROMAW-1:0] a);
        return {a[10:5], a[7:0] ^ 8'hA5}; // Address-dependent, no repeats
    endfunction : rom_f

    // Far side: file registers and ROM answer at once
    always #20 clk = ~clk;
    assign file_rdata = fmem[file_addr];
    assign rom_rdata  = rom_f(rom_addr);
    always @(posedge clk) if (file_we) fmem[file_addr] <= file_wdata;

    task automatic chk(input string n, input logic [13:0] e, g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // Registered state against the model, mid-cycle when settled
    always @(negedge clk) if (rst_n) begin
        chk("acc", m_acc, work_register);
        chk("t0", m_t0, timer0_mode_reg);
        chk("hd", m_hd, table_high_data);
        chk("z", m_z, zero_flag);
        chk("dc", m_dc, half_carry_flag);
        chk("c", m_c, carry_flag);
    end

    // One request; valid is left high so ops run back to back
    task automatic op(input mcuops_op_e k, input logic [7:0] i,
                      input logic [6:0] f, input logic d);
        logic [7:0]  r;
        logic [13:0] w;
        op_valid <= 1'b1;
        op_code <= k;
        op_imm <= i;
        op_faddr <= f;
        op_dest <= d;
        table_high_pointer <= 8'($random(seed));
        @(negedge clk);
        r = (k == MCUOPS_SUBI) ? i - m_acc :
            (k == MCUOPS_XORR) ? m_acc ^ fmem[f] : m_acc ^ i;
        w = rom_f({table_high_pointer[2:0], m_acc});
        chk("ready", 1'h1, op_ready);
        chk("we", k == MCUOPS_XORR && d, file_we);
        if (k == MCUOPS_XORR) chk("wdata", r, file_wdata);
        if (k == MCUOPS_XORR) chk("faddr", f, file_addr);
        if (k == MCUOPS_TABLE)
            chk("raddr", {table_high_pointer[2:0], m_acc}, rom_addr);
        @(posedge clk);
        if (k == MCUOPS_SUBI) begin
            m_c = i >= m_acc;
            m_dc = i[3:0] >= m_acc[3:0];
        end
        if (k inside {MCUOPS_SUBI, MCUOPS_XORI, MCUOPS_XORR}) m_z = r == 0;
        if (k inside {MCUOPS_SUBI, MCUOPS_XORI} || (k == MCUOPS_XORR && !d))
            m_acc = r;
        if (k == MCUOPS_T0LOAD) m_t0 = m_acc;
        if (k == MCUOPS_T0READ) m_acc = m_t0;
        if (k == MCUOPS_TABLE) begin
            op_code <= MCUOPS_XORI; // Must be refused while busy
            op_imm <= 8'hFF;
            @(negedge clk);
            chk("busy", 1'h0, op_ready);
            @(posedge clk);
            m_acc = w[7:0];
            m_hd = {2'h0, w[13:8]};
        end
    endtask : op

    task automatic print_verdict;
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        {m_acc, m_t0, m_hd, m_z, m_dc, m_c} = '0;
        foreach (fmem[j]) fmem[j] = 8'($random(seed));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        op(MCUOPS_XORI, 8'h00, 7'h00, 1'b0);
        op(MCUOPS_SUBI, 8'h05, 7'h00, 1'b0);
        op(MCUOPS_SUBI, 8'h04, 7'h00, 1'b0);
        op(MCUOPS_SUBI, 8'h06, 7'h7F, 1'b1);
        op(MCUOPS_TABLE, 8'h00, 7'h00, 1'b0);
        op(MCUOPS_TABLE, 8'h00, 7'h00, 1'b0);
        repeat (300) begin
            k = mcuops_op_e'(3'($unsigned($random(seed)) % 7));
            r_imm = ($random(seed) & 3) == 0 ? m_acc : 8'($random(seed));
            op(k, r_imm, 7'($random(seed)), 1'($random(seed)));
        end
        op_valid <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        print_verdict();
    end

    // Watchdog well past the longest expected run
    initial begin
        #80000;
        fails++;
        print_verdict();
    end
endmodule : testbench
